// ===== avref_regs.v
// Notes on behaviour
// - x reference built from high/low x registers
// - y reference built from high/low y registers
// - z reference built from high/low z registers
// - high register bits 5:0 give bits 13:8
// - low register gives bits 7:0
// - programmed values used when the select bit or selectOverride is one
// - lsb weight equals one output count
`timescale 1ns/1ps
`default_nettype none
`include "avref_map.vh"
module avref_regs #(
   parameter REF_WIDTH = 14,
   parameter OUT_WIDTH = 16
) (
   input wire clk,
   input wire rst,
   input wire [9:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output wire waitrequest,
   input wire signed [OUT_WIDTH-1:0] sampleRefX,
   input wire signed [OUT_WIDTH-1:0] sampleRefY,
   input wire signed [OUT_WIDTH-1:0] sampleRefZ,
   input wire selectOverride,
   output wire signed [OUT_WIDTH-1:0] refX,
   output wire signed [OUT_WIDTH-1:0] refY,
   output wire signed [OUT_WIDTH-1:0] refZ,
   output wire [1:0] fullScaleSelect,
   output wire refInitSelect
);
   reg [7:0] regFile_r [0:5];
   reg [7:0] ctrl_r;
   reg ack_r;
   wire [7:0] index;
   wire hit;
   wire [2:0] slot;
   wire [3*OUT_WIDTH-1:0] sampleBus;
   wire [3*OUT_WIDTH-1:0] refBus;
   reg [31:0] readdata_nxt;
   integer i;

   // byte address is four times the index
   assign index = address[9:2];
   assign hit = (index >= `AVREF_IDX_X_HIGH) && (index <= `AVREF_IDX_Z_LOW);
   assign slot = index[2:0] - 3'h3;
   // one wait cycle: accesses complete on the edge after ack_r rises
   assign waitrequest = (read | write) & ~ack_r;
   assign refInitSelect = ctrl_r[`AVREF_CTRL_SELECT_BIT] | selectOverride;
   assign fullScaleSelect =
      ctrl_r[`AVREF_CTRL_SCALE_MSB:`AVREF_CTRL_SCALE_LSB];

   always @(posedge clk) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (read | write) & ~ack_r;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         for (i = 0; i < 6; i = i + 1) begin
            if (i[0] == 1'b0) begin
               regFile_r[i] <= `AVREF_HIGH_RESET;
            end else begin
               regFile_r[i] <= `AVREF_LOW_RESET;
            end
         end
         ctrl_r <= `AVREF_CTRL_RESET;
      end else if (write && ack_r && byteenable[0]) begin
         if (hit) begin
            regFile_r[slot] <= writedata[7:0];
         end else if (index == `AVREF_IDX_CTRL) begin
            ctrl_r <= writedata[7:0];
         end
      end
   end

   always @* begin
      readdata_nxt = 32'h00000000;
      if (hit) begin
         readdata_nxt[7:0] = regFile_r[slot];
      end else if (index == `AVREF_IDX_CTRL) begin
         readdata_nxt[7:0] = ctrl_r;
      end else if (index == `AVREF_IDX_STATUS) begin
         readdata_nxt[0] = refInitSelect;
      end
   end

   // unmapped reads return zero, unmapped writes are dropped
   always @(posedge clk) begin
      if (rst) begin
         readdata <= 32'h00000000;
      end else if (read && !ack_r) begin
         readdata <= readdata_nxt;
      end
   end

   // high registers store all eight bits; only 5:0 feed the value
   assign sampleBus = {sampleRefZ, sampleRefY, sampleRefX};
   assign refX = refBus[OUT_WIDTH-1:0];
   assign refY = refBus[2*OUT_WIDTH-1:OUT_WIDTH];
   assign refZ = refBus[3*OUT_WIDTH-1:2*OUT_WIDTH];

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : axis
         avref_axis #(
            .REF_WIDTH(REF_WIDTH),
            .OUT_WIDTH(OUT_WIDTH)
         ) u_avref_axis (
            .highByte(regFile_r[2*g]),
            .lowByte(regFile_r[2*g+1]),
            .sampleRef(sampleBus[g*OUT_WIDTH +: OUT_WIDTH]),
            .initFromRegs(refInitSelect),
            .refValue(),
            .refWide(refBus[g*OUT_WIDTH +: OUT_WIDTH])
         );
      end
   endgenerate
endmodule
`default_nettype wire

// ===== avref_map.vh
`ifndef AVREF_MAP_VH
`define AVREF_MAP_VH
// register offsets are word indexes, not byte addresses
`define AVREF_IDX_X_HIGH 8'h63
`define AVREF_IDX_X_LOW 8'h64
`define AVREF_IDX_Y_HIGH 8'h65
`define AVREF_IDX_Y_LOW 8'h66
`define AVREF_IDX_Z_HIGH 8'h67
`define AVREF_IDX_Z_LOW 8'h68
`define AVREF_IDX_CTRL 8'h70
`define AVREF_IDX_STATUS 8'h71
`define AVREF_HIGH_RESET 8'h00
`define AVREF_LOW_RESET 8'h00
`define AVREF_CTRL_RESET 8'h00
`define AVREF_HIGH_MSB 5
`define AVREF_CTRL_SELECT_BIT 0
`define AVREF_CTRL_SCALE_LSB 1
`define AVREF_CTRL_SCALE_MSB 2
`endif

// ===== avref_axis.v
`timescale 1ns/1ps
`default_nettype none
`include "avref_map.vh"
module avref_axis #(
   parameter REF_WIDTH = 14,
   parameter OUT_WIDTH = 16
) (
   input wire [7:0] highByte,
   input wire [7:0] lowByte,
   input wire signed [OUT_WIDTH-1:0] sampleRef,
   input wire initFromRegs,
   output wire signed [REF_WIDTH-1:0] refValue,
   output wire signed [OUT_WIDTH-1:0] refWide
);
   wire signed [REF_WIDTH-1:0] progRef;
   wire signed [OUT_WIDTH-1:0] progWide;
   // upper six bits, then the low byte
   assign progRef = {highByte[`AVREF_HIGH_MSB:0], lowByte};
   // bit 13 is the sign; extend for wider arithmetic
   assign progWide = {{(OUT_WIDTH-REF_WIDTH){progRef[REF_WIDTH-1]}},
      progRef};
   assign refValue = progRef;
   // counts at the same weight as output data, so no rescale by range
   assign refWide = initFromRegs ? progWide : sampleRef;
endmodule
`default_nettype wire

// ===== avref_checker.sv
`timescale 1ns/1ps
`default_nettype none
module avref_checker(
   input wire clk,
   input wire rst,
   input wire [9:0] address,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   input wire waitrequest,
   input wire signed [15:0] sampleRefX,
   input wire selectOverride,
   input wire signed [15:0] refX,
   input wire signed [15:0] refY,
   input wire signed [15:0] refZ,
   input wire refInitSelect
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire s = refInitSelect;
   wire tk = write && !waitrequest && byteenable[0];
   property p_pa; !s |-> refX == sampleRefX; endproperty
   a_pa: assert property (p_pa) else $error("x ref not sample");
   property p_ov; selectOverride |-> s; endproperty
   a_ov: assert property (p_ov) else $error("override ignored");
   property p_sx; s |-> refX[15:14] == {2{refX[13]}}; endproperty
   a_sx: assert property (p_sx) else $error("x sign bad");
   property p_sy; s |-> refY[15:14] == {2{refY[13]}}; endproperty
   a_sy: assert property (p_sy) else $error("y sign bad");
   property p_sz; s |-> refZ[15:14] == {2{refZ[13]}}; endproperty
   a_sz: assert property (p_sz) else $error("z sign bad");
   property p_hi; tk && address[9:2] == 8'h63
      |=> !s || refX[13:8] == $past(writedata[5:0]); endproperty
   a_hi: assert property (p_hi) else $error("x high bad");
   property p_lo; tk && address[9:2] == 8'h64
      |=> !s || refX[7:0] == $past(writedata[7:0]); endproperty
   a_lo: assert property (p_lo) else $error("x low bad");
   property p_wt; write && waitrequest |=> !waitrequest; endproperty
   a_wt: assert property (p_wt) else $error("wait too long");
endmodule
bind avref_regs avref_checker u_avref_checker(.clk, .rst, .address,
   .write, .writedata, .byteenable, .waitrequest, .sampleRefX,
   .selectOverride, .refX, .refY, .refZ, .refInitSelect);
`default_nettype wire

// ===== avref_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module avref_regs_bench;
   reg clk = 0, rst = 1, read = 0, write = 0, selectOverride = 0;
   reg [9:0] address = 0;
   reg [31:0] writedata = 0, rd;
   reg [3:0] be = 4'hF;
   reg signed [15:0] sr = 16'h1234;
   reg [0:6][7:0] v = 56'hE5811A3C2000FF;
   wire [31:0] readdata;
   wire [1:0] fullScaleSelect;
   wire waitrequest, refInitSelect;
   wire signed [15:0] refX, refY, refZ;
   integer errCount = 0, checked = 0, i;
   avref_regs u_avref_regs(.clk, .rst, .address, .read, .write,
      .writedata, .byteenable(be), .readdata, .waitrequest,
      .sampleRefX(sr), .sampleRefY(sr), .sampleRefZ(sr), .selectOverride,
      .refX, .refY, .refZ, .fullScaleSelect, .refInitSelect);
   initial forever #5 clk = ~clk;
   task chk(input [31:0] g, e);
      checked++;
      if (g !== e) begin
         errCount++;
         $display("unexpected %0t mismatch got %h want %h", $time, g, e);
      end
   endtask
   task acc(input w, input [7:0] a, d);
      @(posedge clk);
      address <= {a, 2'b00};
      writedata <= {24'h0, d};
      read <= !w;
      write <= w;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 0;
      write <= 0;
   endtask
   function signed [15:0] ext(input integer a);
      ext = {{2{v[a][5]}}, v[a][5:0], v[a+1]};
   endfunction
   task end_sim;
      $display("checks %0d errors %0d", checked, errCount);
      if (errCount == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task t_regs;
      // index 0x69 is unmapped: reads stay zero
      for (i = 0; i < 7; i++) begin
         acc(0, 8'h63 + i, 0);
         chk(rd, 0);
         acc(1, 8'h63 + i, v[i]);
         acc(0, 8'h63 + i, 0);
         chk(rd, i < 6 ? v[i] : 0);
      end
      acc(1, 8'h70, 8'h07);
      @(negedge clk);
      chk(refX, ext(0));
      chk(refY, ext(2));
      chk(refZ, ext(4));
      chk(fullScaleSelect, 3);
      chk(refInitSelect, 1);
      $display("regs done");
   endtask
   task t_sel;
      acc(1, 8'h70, 0);
      @(negedge clk);
      chk(refX, sr);
      chk(refInitSelect, 0);
      @(posedge clk);
      selectOverride <= 1;
      acc(1, 8'h63, 8'h1F);
      acc(1, 8'h64, 8'h00);
      @(negedge clk);
      chk(refX, 16'h1F00);
      acc(0, 8'h71, 0);
      chk(rd, 1);
      // byte lane 0 off: the write must be dropped
      be <= 4'hE;
      acc(1, 8'h64, 8'h55);
      be <= 4'hF;
      acc(0, 8'h64, 0);
      chk(rd, 0);
      $display("select done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      t_regs;
      t_sel;
      end_sim;
   end
   initial begin
      #20000;
      errCount++;
      end_sim;
   end
endmodule
`default_nettype wire
